// ### verilog/common_signals_pkg.sv
`default_nettype none
package common_signals_pkg;

  // ************************************************************
  // sizes of the aggregation
  // ************************************************************
  localparam int NUM_FUNCS    = 16;  // protection functions feeding the block
  localparam int NUM_EXTRA    = 8;   // user-assignable extra inputs per output
  localparam int COUNT_WIDTH  = 16;  // activation counter width
  localparam int STAMP_WIDTH  = 32;  // time stamp width
  localparam int SOURCE_WIDTH = 8;   // event source identifier width

  // ************************************************************
  // codes and reset values
  // ************************************************************
  // identifier of this event block, value is arbitrary
  localparam logic [SOURCE_WIDTH-1:0] AGGREGATE_STATUS_EVENT_SOURCE = 8'h5A;
  localparam logic [COUNT_WIDTH-1:0]  COUNT_RESET = 16'h0000;
  localparam logic [COUNT_WIDTH-1:0]  COUNT_MAX   = 16'hFFFF;
  localparam logic [STAMP_WIDTH-1:0]  STAMP_RESET = 32'h0000_0000;
  // event mask field positions: bit 0 keeps ON events, bit 1 keeps OFF events
  localparam int MASK_ON_BIT  = 0;
  localparam int MASK_OFF_BIT = 1;
  localparam logic [1:0] MASK_RESET = 2'h3;

  typedef enum logic [1:0] {
    force_normal,
    force_start,
    force_trip
  } forced_status_type;

  typedef enum logic [1:0] {
    cond_normal,
    cond_start,
    cond_trip
  } condition_type;

endpackage : common_signals_pkg
`default_nettype wire

// ### verilog/event_gate.sv
`timescale 1ns/1ps
`default_nettype none
module event_gate (
  input  wire logic                                       sys_clk,
  input  wire logic                                       reset,
  input  wire logic                                       clk_en,
  input  wire logic                                       level_now,
  input  wire logic                                       level_next,
  input  wire logic [1:0]                                 mask,
  input  wire logic [common_signals_pkg::STAMP_WIDTH-1:0] time_now,
  output logic                                            event_valid,
  output logic                                            event_on,
  output logic [common_signals_pkg::STAMP_WIDTH-1:0]      event_stamp
);
  import common_signals_pkg::*;

  // ************************************************************
  // transition detection and masking
  // ************************************************************
  logic rising;
  logic falling;
  logic keep;
  // edges seen one cycle ahead so the stamp lands with the output change
  assign rising  = level_next & ~level_now;
  assign falling = ~level_next & level_now;
  assign keep    = (rising & mask[MASK_ON_BIT]) | (falling & mask[MASK_OFF_BIT]);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      event_valid <= 1'b0;
      event_on    <= 1'b0;
      event_stamp <= STAMP_RESET;
    end else if (clk_en) begin
      event_valid <= keep;
      if (keep) begin
        event_on    <= rising;
        event_stamp <= time_now;
      end
    end
  end

endmodule : event_gate
`default_nettype wire

// ### verilog/common_signals.sv
`timescale 1ns/1ps
`default_nettype none
module common_signals (
  input  wire logic                                        sys_clk,
  input  wire logic                                        reset,
  input  wire logic                                        clk_en,
  // protection function side
  input  wire logic [common_signals_pkg::NUM_FUNCS-1:0]    func_enable,
  input  wire logic [common_signals_pkg::NUM_FUNCS-1:0]    func_start,
  input  wire logic [common_signals_pkg::NUM_FUNCS-1:0]    func_trip,
  // user-assigned extra sources
  input  wire logic [common_signals_pkg::NUM_EXTRA-1:0]    extra_start_in,
  input  wire logic [common_signals_pkg::NUM_EXTRA-1:0]    extra_start_assign,
  input  wire logic [common_signals_pkg::NUM_EXTRA-1:0]    extra_trip_in,
  input  wire logic [common_signals_pkg::NUM_EXTRA-1:0]    extra_trip_assign,
  // general settings
  input  wire logic                                        stage_forcing_enable,
  input  wire logic                                        settings_write,
  input  wire logic [1:0]                                  forced_status_select,
  input  wire logic [1:0]                                  start_event_mask,
  input  wire logic [1:0]                                  trip_event_mask,
  // time base and counter clears
  input  wire logic [common_signals_pkg::STAMP_WIDTH-1:0]  time_now,
  input  wire logic                                        start_count_clear,
  input  wire logic                                        trip_count_clear,
  // aggregated outputs
  output logic                                             common_start,
  output logic                                             common_trip,
  output common_signals_pkg::condition_type                condition,
  output logic [1:0]                                       forced_status_active,
  // event outputs
  output logic [common_signals_pkg::SOURCE_WIDTH-1:0]      event_source,
  output logic                                             start_event_valid,
  output logic                                             start_event_on,
  output logic [common_signals_pkg::STAMP_WIDTH-1:0]       start_event_stamp,
  output logic                                             trip_event_valid,
  output logic                                             trip_event_on,
  output logic [common_signals_pkg::STAMP_WIDTH-1:0]       trip_event_stamp,
  // counters
  output logic [common_signals_pkg::COUNT_WIDTH-1:0]       start_count,
  output logic [common_signals_pkg::COUNT_WIDTH-1:0]       trip_count
);
  import common_signals_pkg::*;

  // ************************************************************
  // static general settings
  // ************************************************************
  forced_status_type forced_setting;
  logic [1:0]        start_mask;
  logic [1:0]        trip_mask;
  forced_status_type written_force;
  logic              force_write_ok;

  // unused code 3 is folded to normal so a bad write cannot latch a force
  assign written_force  = (forced_status_select == 2'h1) ? force_start :
                          (forced_status_select == 2'h2) ? force_trip  : force_normal;
  assign force_write_ok = settings_write & stage_forcing_enable;

  // settings change only on explicit write
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      forced_setting <= force_normal;
      start_mask     <= MASK_RESET;
      trip_mask      <= MASK_RESET;
    end else if (clk_en) begin
      if (force_write_ok) begin
        forced_setting <= written_force;
      end
      if (settings_write) begin
        start_mask <= start_event_mask;
        trip_mask  <= trip_event_mask;
      end
    end
  end

  // ************************************************************
  // aggregation
  // ************************************************************
  logic              start_any;
  logic              trip_any;
  logic              start_extra;
  logic              trip_extra;
  forced_status_type effective_force;
  logic              next_start;
  logic              next_trip;
  condition_type     next_condition;

  // suppression happens upstream, no block input here
  assign start_any   = |(func_start & func_enable);
  assign trip_any    = |(func_trip & func_enable);
  assign start_extra = |(extra_start_in & extra_start_assign);
  assign trip_extra  = |(extra_trip_in & extra_trip_assign);

  // force ignored when disabled
  // disabling the global enable drops the force at once, setting is kept
  assign effective_force = stage_forcing_enable ? forced_setting : force_normal;

  always_comb begin
    next_start = start_any | start_extra;
    next_trip  = trip_any | trip_extra;
    unique case (effective_force)
      force_normal: begin
        next_start = start_any | start_extra;
        next_trip  = trip_any | trip_extra;
      end
      force_start: begin
        next_start = 1'b1;
        next_trip  = 1'b0;
      end
      force_trip: begin
        next_start = 1'b1;
        next_trip  = 1'b1;
      end
      default: begin
        next_start = start_any | start_extra;
        next_trip  = trip_any | trip_extra;
      end
    endcase
  end

  assign next_condition = next_trip  ? cond_trip  :
                          next_start ? cond_start : cond_normal;

  // registered outputs and indication
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      common_start         <= 1'b0;
      common_trip          <= 1'b0;
      condition            <= cond_normal;
      forced_status_active <= 2'h0;
      event_source         <= AGGREGATE_STATUS_EVENT_SOURCE;
    end else if (clk_en) begin
      common_start         <= next_start;
      common_trip          <= next_trip;
      condition            <= next_condition;
      forced_status_active <= effective_force;
      event_source         <= AGGREGATE_STATUS_EVENT_SOURCE;
    end
  end

  // ************************************************************
  // events
  // ************************************************************
  // start on/off events
  event_gate start_gate (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .level_now   (common_start),
    .level_next  (next_start),
    .mask        (start_mask),
    .time_now    (time_now),
    .event_valid (start_event_valid),
    .event_on    (start_event_on),
    .event_stamp (start_event_stamp)
  );

  event_gate trip_gate (
    .sys_clk     (sys_clk),
    .reset       (reset),
    .clk_en      (clk_en),
    .level_now   (common_trip),
    .level_next  (next_trip),
    .mask        (trip_mask),
    .time_now    (time_now),
    .event_valid (trip_event_valid),
    .event_on    (trip_event_on),
    .event_stamp (trip_event_stamp)
  );

  // ************************************************************
  // activation counters
  // ************************************************************
  logic                   start_rise;
  logic                   trip_rise;
  logic [COUNT_WIDTH-1:0] next_start_count;
  logic [COUNT_WIDTH-1:0] next_trip_count;

  // saturating step, counting past the top would fake a low count
  function automatic logic [COUNT_WIDTH-1:0] count_step(
    input logic [COUNT_WIDTH-1:0] value,
    input logic                   clear,
    input logic                   hit
  );
    logic [COUNT_WIDTH-1:0] base;
    base = clear ? COUNT_RESET : value;
    if (hit && base != COUNT_MAX) begin
      count_step = base + 16'h0001;
    end else begin
      count_step = base;
    end
  endfunction : count_step

  assign start_rise       = next_start & ~common_start;
  assign trip_rise        = next_trip & ~common_trip;
  // clear and count, activation not lost
  assign next_start_count = count_step(start_count, start_count_clear, start_rise);
  assign next_trip_count  = count_step(trip_count, trip_count_clear, trip_rise);

  // counter registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      start_count <= COUNT_RESET;
      trip_count  <= COUNT_RESET;
    end else if (clk_en) begin
      start_count <= next_start_count;
      trip_count  <= next_trip_count;
    end
  end

endmodule : common_signals
`default_nettype wire

// ### tb/common_signals_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// watcher of the aggregated outputs
// ***********************************
module common_signals_chk
  import common_signals_pkg::*;
(
  input wire logic                   sys_clk,
  input wire logic                   reset,
  input wire logic                   clk_en,
  input wire logic [NUM_FUNCS-1:0]   func_enable,
  input wire logic [NUM_FUNCS-1:0]   func_start,
  input wire logic [NUM_FUNCS-1:0]   func_trip,
  input wire logic [NUM_EXTRA-1:0]   extra_start_in,
  input wire logic [NUM_EXTRA-1:0]   extra_start_assign,
  input wire logic [NUM_EXTRA-1:0]   extra_trip_in,
  input wire logic [NUM_EXTRA-1:0]   extra_trip_assign,
  input wire logic                   trip_count_clear,
  input wire logic                   common_start,
  input wire logic                   common_trip,
  input wire condition_type          condition,
  input wire logic [1:0]             forced_status_active,
  input wire logic                   start_event_valid,
  input wire logic                   start_event_on,
  input wire logic [COUNT_WIDTH-1:0] start_count,
  input wire logic [COUNT_WIDTH-1:0] trip_count
);
  wire any_start = |(func_enable & func_start) | |(extra_start_in & extra_start_assign);
  wire any_trip  = |(func_enable & func_trip) | |(extra_trip_in & extra_trip_assign);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  chk_start_any: assert property (clk_en && any_start |=> common_start)
    else $error("common start missing");
  chk_trip_any: assert property (clk_en && any_trip |=> common_trip || forced_status_active == 2'h1)
    else $error("common trip missing");
  chk_idle_level: assert property (clk_en && !any_start && !any_trip |=> common_start == (forced_status_active != 2'h0))
    else $error("start level wrong when idle");
  chk_force_trip: assert property (forced_status_active == 2'h2 |-> common_start && common_trip)
    else $error("forced trip lacks an output");
  chk_cond_map: assert property (condition == (common_trip ? cond_trip : common_start ? cond_start : cond_normal))
    else $error("condition disagrees with outputs");
  // a frozen clock enable holds the pulse, so only a fresh pulse is judged
  chk_event_edge: assert property (start_event_valid && $past(clk_en)
    |-> $changed(common_start) && start_event_on == common_start)
    else $error("start event without matching edge");
  chk_count_rise: assert property (!$stable(start_count) |-> $rose(common_start) || start_count == 16'h0000)
    else $error("start count moved without a rise");
  chk_trip_step: assert property ($rose(common_trip) && !$past(trip_count_clear)
    && $past(trip_count) != 16'hFFFF |-> trip_count == $past(trip_count) + 16'h0001)
    else $error("trip count did not step by one");
  cover property (start_event_valid && !start_event_on);
  cover property (forced_status_active == 2'h2);
  cover property ($rose(common_trip));
endmodule : common_signals_chk
bind common_signals common_signals_chk common_signals_chk_i (.sys_clk, .reset, .clk_en,
  .func_enable, .func_start, .func_trip, .extra_start_in, .extra_start_assign, .extra_trip_in,
  .extra_trip_assign, .trip_count_clear, .common_start, .common_trip, .condition,
  .forced_status_active, .start_event_valid, .start_event_on, .start_count, .trip_count);
`default_nettype wire

// ### tb/source_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// protection functions and extra sources
// ***********************************
module source_model
  import common_signals_pkg::*;
(
  output logic [NUM_FUNCS-1:0] func_enable,
  output logic [NUM_FUNCS-1:0] func_start,
  output logic [NUM_FUNCS-1:0] func_trip,
  output logic [NUM_EXTRA-1:0] extra_start_in,
  output logic [NUM_EXTRA-1:0] extra_start_assign,
  output logic [NUM_EXTRA-1:0] extra_trip_in,
  output logic [NUM_EXTRA-1:0] extra_trip_assign
);
  logic [NUM_FUNCS-1:0] raw_trip;
  logic [NUM_FUNCS-1:0] held_off = 16'h0000;
  assign func_trip = raw_trip & ~held_off;  // suppression never reaches the block
  task automatic drive(input logic [15:0] en, st, tr, input logic [7:0] xs, xa, xt, xb);
    {func_enable, func_start, raw_trip} = {en, st, tr};
    {extra_start_in, extra_start_assign, extra_trip_in, extra_trip_assign} = {xs, xa, xt, xb};
  endtask : drive
  // blocking applied inside a function, upstream of the block
  task automatic hold(input logic [15:0] h);
    held_off = h;
  endtask : hold
  initial drive(16'h0000, 16'h0000, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
endmodule : source_model
`default_nettype wire

// ### tb/common_signals_test.sv
`timescale 1ns/1ps
`default_nettype none
// ***********************************
// self-checking bench
// ***********************************
module common_signals_test;
  import common_signals_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, stage_forcing_enable = 1'b0;
  logic settings_write = 1'b0, start_count_clear = 1'b0, trip_count_clear = 1'b0;
  logic [1:0] forced_status_select = 2'h0, start_event_mask = 2'h3, trip_event_mask = 2'h3;
  logic [31:0] time_now = 32'h0000_0000, t;
  logic [15:0] func_enable, func_start, func_trip, start_count, trip_count;
  logic [7:0] extra_start_in, extra_start_assign, extra_trip_in, extra_trip_assign, event_source;
  logic common_start, common_trip, start_event_valid, start_event_on, trip_event_valid, trip_event_on;
  logic [1:0] forced_status_active;
  logic [31:0] start_event_stamp, trip_event_stamp;
  condition_type condition;
  int num_errors = 0, total_checks = 0;
  always #5 sys_clk = ~sys_clk;
  source_model source_model_i (.func_enable, .func_start, .func_trip, .extra_start_in,
    .extra_start_assign, .extra_trip_in, .extra_trip_assign);
  common_signals common_signals_i (.sys_clk, .reset, .clk_en, .func_enable, .func_start, .func_trip,
    .extra_start_in, .extra_start_assign, .extra_trip_in, .extra_trip_assign, .stage_forcing_enable,
    .settings_write, .forced_status_select, .start_event_mask, .trip_event_mask, .time_now,
    .start_count_clear, .trip_count_clear, .common_start, .common_trip, .condition,
    .forced_status_active, .event_source, .start_event_valid, .start_event_on, .start_event_stamp,
    .trip_event_valid, .trip_event_on, .trip_event_stamp, .start_count, .trip_count);
  task automatic step(input int n = 1);
    repeat (n) begin
      @(posedge sys_clk);
      #1 time_now = time_now + 32'h0000_0001;  // inputs move 1 ns after the edge
    end
  endtask : step
  task automatic check(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic src(input logic [15:0] en, st, tr, input logic [7:0] xs, xa, xt, xb);
    source_model_i.drive(en, st, tr, xs, xa, xt, xb);
    t = time_now;
    step();
  endtask : src
  task automatic agg_start;
    src(16'h0001, 16'h0008, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
    check(common_start, 1'b0);
    src(16'h0009, 16'h0008, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
    check({start_event_valid, start_event_on, common_start}, 3'h7);
    check(start_event_stamp, t);
    check(condition, cond_start);
    step(3);
    check({start_event_valid, start_count}, 17'h00001);
    src(16'h0009, 16'h0000, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
    check({start_event_valid, start_event_on, common_start}, 3'h4);
  endtask : agg_start
  task automatic extras;
    src(16'h0000, 16'h0000, 16'h0000, 8'h02, 8'h01, 8'h00, 8'h00);
    check(common_start, 1'b0);
    src(16'h0000, 16'h0000, 16'h0000, 8'h03, 8'h01, 8'h10, 8'h10);
    check({common_start, common_trip, trip_event_valid, trip_count}, 19'h70001);
    check(condition, cond_trip);
    check(trip_event_stamp, t);
    check(trip_event_on, 1'b1);
    trip_count_clear = 1'b1;
    step();
    trip_count_clear = 1'b0;
    check({start_count, trip_count}, 32'h0002_0000);
    src(16'h0000, 16'h0000, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
  endtask : extras
  task automatic forcing;
    {settings_write, forced_status_select} = 3'h6;
    step(2);
    check(common_trip, 1'b0);
    {stage_forcing_enable, settings_write} = 2'h3;
    step();
    {settings_write, forced_status_select} = 3'h1;
    step(2);
    check({common_start, common_trip, forced_status_active}, 4'hE);
    stage_forcing_enable = 1'b0;
    step();
    check({common_start, common_trip, forced_status_active}, 4'h0);
    stage_forcing_enable = 1'b1;
    step();
    check(common_trip, 1'b1);
    {settings_write, forced_status_select} = 3'h4;
    step(2);
    check(forced_status_active, 2'h0);
    settings_write = 1'b0;
  endtask : forcing
  task automatic masking;
    trip_event_mask = 2'h1;
    {settings_write, start_event_mask} = 3'h6;
    step();
    settings_write = 1'b0;
    src(16'h0001, 16'h0001, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
    check({common_start, start_event_valid}, 2'h2);
    src(16'h0001, 16'h0000, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
    check({start_event_valid, start_event_on}, 2'h2);
  endtask : masking
  task automatic freeze;
    step();
    clk_en = 1'b0;
    src(16'h0001, 16'h0001, 16'h0001, 8'h00, 8'h00, 8'h00, 8'h00);
    step(2);
    check({common_start, common_trip, start_event_valid, trip_event_valid}, 4'h0);
    check({start_count, trip_count}, 32'h0005_0002);
    clk_en = 1'b1;
    step();
    check({common_start, common_trip, trip_event_valid, trip_event_on}, 4'hF);
    check({start_count, trip_count}, 32'h0006_0003);
  endtask : freeze
  task automatic clears;
    start_count_clear = 1'b1;
    step();
    start_count_clear = 1'b0;
    check({start_count, trip_count}, 32'h0000_0003);
    src(16'h0000, 16'h0000, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
    check({trip_event_valid, common_trip}, 2'h0);
    trip_count_clear = 1'b1;
    src(16'h0001, 16'h0000, 16'h0001, 8'h00, 8'h00, 8'h00, 8'h00);
    trip_count_clear = 1'b0;
    check(trip_count, 16'h0001);
    reset = 1'b1;
    step();
    reset = 1'b0;
    check({common_trip, condition, trip_count}, 19'h00000);
    step();
    check({common_trip, trip_event_valid, trip_count}, 18'h30001);
    src(16'h0000, 16'h0000, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
    check({trip_event_valid, trip_event_on}, 2'h2);
    source_model_i.hold(16'h0001);
    src(16'h0001, 16'h0000, 16'h0001, 8'h00, 8'h00, 8'h00, 8'h00);
    check(common_trip, 1'b0);
    source_model_i.hold(16'h0000);
    src(16'h0000, 16'h0000, 16'h0000, 8'h00, 8'h00, 8'h00, 8'h00);
  endtask : clears
  task automatic stop_test;
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    step(6);
    reset = 1'b0;
    step();
    check({event_source, condition, start_count}, {AGGREGATE_STATUS_EVENT_SOURCE, 18'h0});
    agg_start();
    extras();
    forcing();
    masking();
    freeze();
    clears();
    stop_test();
  end
endmodule : common_signals_test
`default_nettype wire
